/* File: hdl/ir_prox_consts.vh */
// Contract
// - integrating converter yields results of up to 16 bits
// - integration time counts oscillator cycles, 4/8/12/16-bit counter
// - host selects range 1 (dim) up to range 4 (bright)
// - start in power-down, no conversions until host commands one
// - result registers hold zero until a conversion completes
// - one-shot: single conversion, self power-down, result kept readable
// - continuous: back-to-back conversions, each overwrites the result
// - writing power-down mode stops converting
// - modes may be written one after another; each is adopted
// - result is unsigned, width equals selected resolution, max 16
// - led driver on during proximity sensing, off during ir sensing
// - led amplitude and modulation from second command register apply
// - interrupt pin active low open drain, only pulls low
// - interrupt condition mirrored in a readable status bit
// - interrupt when result above upper or below lower threshold
// - interrupt only after set number of consecutive out-of-window cycles
// - mode codes 000 off, 010/011 once, 110/111 continuous
// - persistence codes 00..11 map to 1, 4, 8, 16 cycles
// - pin and flag hold until a first command register transfer ends
// - resolution codes 00..11 give 65536/4096/256/16 cycles, 16/12/8/4 bits
`ifndef IR_PROX_CONSTS_VH
`define IR_PROX_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_CMD1      3'h0
`define IDX_CMD2      3'h1
`define IDX_DATA_LSB  3'h2
`define IDX_DATA_MSB  3'h3
`define IDX_LT_LSB    3'h4
`define IDX_LT_MSB    3'h5
`define IDX_HT_LSB    3'h6
`define IDX_HT_MSB    3'h7

// command register 1 fields
`define MODE_HI       7
`define MODE_LO       5
`define FLAG_BIT      2
`define PRST_HI       1
`define PRST_LO       0
// command register 2 fields
`define SCHEME_BIT    7
`define FREQ_BIT      6
`define IS_HI         5
`define IS_LO         4
`define RES_HI        3
`define RES_LO        2
`define RANGE_HI      1
`define RANGE_LO      0

// mode encodings
`define MODE_OFF      3'h0
`define MODE_IR_ONCE  3'h2
`define MODE_PX_ONCE  3'h3
`define MODE_IR_CONT  3'h6
`define MODE_PX_CONT  3'h7

// reset values
`define RST_CMD       8'h00
`define RST_LT        16'h0000
`define RST_HT        16'hffff
`define RST_DATA      16'h0000

// led modulation timing
`define CLK_KHZ       50000
`define MOD_KHZ       360
`define MOD_HALF      (`CLK_KHZ / (2 * `MOD_KHZ))

`endif

/* File: hdl/ir_proximity_sensor_sequencer.v */
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "ir_prox_consts.vh"

module ir_proximity_sensor_sequencer (
    // clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    // converter side
    input  wire        osc_clk,
    input  wire        photo_pulse,
    output wire        adc_active,
    output reg  [1:0]  adc_range,
    output reg  [15:0] result_mask,
    // led driver
    output reg         led_drive_output,
    output reg  [1:0]  led_current,
    // open-drain interrupt pin
    output wire        int_n_out,
    output wire        int_n_oe
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_INTEG = 1'b1;
    localparam integer MOD_WRAP = `MOD_HALF - 1;
    localparam [6:0]   MOD_LAST = MOD_WRAP[6:0];

    // =========================================================
    // functions
    // =========================================================
    function [15:0] res_max;
        input [1:0] res;
        begin
            case (res)
                2'h0:    res_max = 16'hffff;
                2'h1:    res_max = 16'h0fff;
                2'h2:    res_max = 16'h00ff;
                2'h3:    res_max = 16'h000f;
                default: res_max = 16'hffff;
            endcase
        end
    endfunction

    function [4:0] persist_len;
        input [1:0] code;
        begin
            case (code)
                2'h0:    persist_len = 5'h01;
                2'h1:    persist_len = 5'h04;
                2'h2:    persist_len = 5'h08;
                2'h3:    persist_len = 5'h10;
                default: persist_len = 5'h01;
            endcase
        end
    endfunction

    function mode_runs;
        input [2:0] m;
        begin
            case (m)
                `MODE_IR_ONCE: mode_runs = 1'b1;
                `MODE_PX_ONCE: mode_runs = 1'b1;
                `MODE_IR_CONT: mode_runs = 1'b1;
                `MODE_PX_CONT: mode_runs = 1'b1;
                default:       mode_runs = 1'b0;
            endcase
        end
    endfunction

    // =========================================================
    // registers
    // =========================================================
    reg  [2:0]  mode;
    reg  [1:0]  persist;
    reg         flag;
    reg         scheme;
    reg         freq;
    reg  [1:0]  res;
    reg  [15:0] result;
    reg  [15:0] thr_lo;
    reg  [15:0] thr_hi;

    reg         state;
    reg  [15:0] tick_cnt;
    reg  [15:0] pulse_cnt;
    reg  [4:0]  oow_cnt;
    wire        next_flag;

    reg         ph_valid;
    reg         ph_write;
    reg  [2:0]  ph_idx;

    reg  [2:0]  osc_sync;
    reg  [2:0]  pd_sync;
    reg  [6:0]  mod_cnt;
    reg         mod_phase;

    // =========================================================
    // input synchronisers and edge finding
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_sync <= 3'h0;
            pd_sync  <= 3'h0;
        end else begin
            osc_sync <= {osc_sync[1:0], osc_clk};
            pd_sync  <= {pd_sync[1:0], photo_pulse};
        end
    end

    // edges seen only between second and third stage
    wire osc_tick = osc_sync[1] & ~osc_sync[2];
    wire pd_rise  = pd_sync[1] & ~pd_sync[2];

    // =========================================================
    // ahb-lite slave
    // =========================================================
    wire        take    = hsel & htrans[1] & hready;
    wire        in_map  = (haddr[31:5] == 27'h0);
    wire [2:0]  a_idx   = haddr[4:2];
    wire        wr_now  = ph_valid & ph_write;
    wire        wr_cmd1 = wr_now & (ph_idx == `IDX_CMD1);
    wire        wr_cmd2 = wr_now & (ph_idx == `IDX_CMD2);
    wire        cmd1_done = ph_valid & (ph_idx == `IDX_CMD1);
    wire [7:0]  wbyte   = hwdata[7:0];
    wire [2:0]  seen_mode = wr_cmd1 ? wbyte[`MODE_HI:`MODE_LO] : mode;
    wire [1:0]  seen_prst = wr_cmd1 ? wbyte[`PRST_HI:`PRST_LO] : persist;

    // a write still in its data phase is seen by a read right behind it
    function [7:0] fresh;
        input [7:0] stored;
        begin
            if (wr_now && (ph_idx == a_idx)) begin
                fresh = wbyte;
            end else begin
                fresh = stored;
            end
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_idx   <= 3'h0;
        end else begin
            ph_valid <= take & in_map;
            ph_write <= hwrite;
            ph_idx   <= a_idx;
        end
    end

    // read data registered during the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (take) begin
            hrdata <= 32'h0;
            if (in_map && !hwrite) begin
                case (a_idx)
                    `IDX_CMD1:
                        hrdata[7:0] <= {seen_mode, 2'h0,
                                        next_flag, seen_prst};
                    `IDX_CMD2:
                        hrdata[7:0] <= fresh({scheme, freq, led_current,
                                              res, adc_range});
                    `IDX_DATA_LSB: hrdata[7:0] <= result[7:0];
                    `IDX_DATA_MSB: hrdata[7:0] <= result[15:8];
                    `IDX_LT_LSB:
                        hrdata[7:0] <= fresh(thr_lo[7:0]);
                    `IDX_LT_MSB:
                        hrdata[7:0] <= fresh(thr_lo[15:8]);
                    `IDX_HT_LSB:
                        hrdata[7:0] <= fresh(thr_hi[7:0]);
                    `IDX_HT_MSB:
                        hrdata[7:0] <= fresh(thr_hi[15:8]);
                    default:       hrdata[7:0] <= 8'h0;
                endcase
            end
        end
    end

    // =========================================================
    // command register 2 and thresholds
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scheme      <= 1'b0;
            freq        <= 1'b0;
            led_current <= 2'h0;
            res         <= 2'h0;
            adc_range   <= 2'h0;
            thr_lo      <= `RST_LT;
            thr_hi      <= `RST_HT;
        end else if (wr_now) begin
            case (ph_idx)
                `IDX_CMD2: begin
                    scheme      <= wbyte[`SCHEME_BIT];
                    freq        <= wbyte[`FREQ_BIT];
                    led_current <= wbyte[`IS_HI:`IS_LO];
                    res         <= wbyte[`RES_HI:`RES_LO];
                    adc_range   <= wbyte[`RANGE_HI:`RANGE_LO];
                end
                `IDX_LT_LSB: thr_lo[7:0]  <= wbyte;
                `IDX_LT_MSB: thr_lo[15:8] <= wbyte;
                `IDX_HT_LSB: thr_hi[7:0]  <= wbyte;
                `IDX_HT_MSB: thr_hi[15:8] <= wbyte;
                default: thr_lo <= thr_lo;
            endcase
        end
    end

    // =========================================================
    // conversion sequencer
    // =========================================================
    wire [15:0] cur_max    = res_max(res);
    wire        pd_count   = pd_rise & (pulse_cnt != cur_max);
    wire [15:0] next_pulse = pulse_cnt + {15'h0, pd_count};
    wire        finish     = (state == ST_INTEG) & osc_tick &
                             (tick_cnt == cur_max) & ~wr_cmd1;
    wire        out_win    = (next_pulse > thr_hi) |
                             (next_pulse < thr_lo);
    wire [4:0]  next_oow   = oow_cnt + 5'h01;
    wire        trig       = finish & out_win &
                             (next_oow >= persist_len(persist));
    wire        one_shot   = ~mode[2];

    assign adc_active = (state == ST_INTEG);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state       <= ST_IDLE;
            mode        <= `MODE_OFF;
            persist     <= 2'h0;
            tick_cnt    <= 16'h0;
            pulse_cnt   <= 16'h0;
            oow_cnt     <= 5'h0;
            result      <= `RST_DATA;
            result_mask <= 16'hffff;
        end else if (wr_cmd1) begin
            mode      <= wbyte[`MODE_HI:`MODE_LO];
            persist   <= wbyte[`PRST_HI:`PRST_LO];
            tick_cnt  <= 16'h0;
            pulse_cnt <= 16'h0;
            oow_cnt   <= 5'h0;
            if (mode_runs(wbyte[`MODE_HI:`MODE_LO])) begin
                state <= ST_INTEG;
            end else begin
                state <= ST_IDLE;
            end
        end else begin
            case (state)
                ST_IDLE: begin
                    tick_cnt  <= 16'h0;
                    pulse_cnt <= 16'h0;
                end
                ST_INTEG: begin
                    if (finish) begin
                        // whole word replaced in one edge
                        result      <= next_pulse;
                        result_mask <= cur_max;
                        tick_cnt    <= 16'h0;
                        pulse_cnt   <= 16'h0;
                        if (out_win) begin
                            if (next_oow < persist_len(persist)) begin
                                oow_cnt <= next_oow;
                            end
                        end else begin
                            oow_cnt <= 5'h0;
                        end
                        if (one_shot) begin
                            mode  <= `MODE_OFF;
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_INTEG;
                        end
                    end else begin
                        pulse_cnt <= next_pulse;
                        if (osc_tick) begin
                            tick_cnt <= tick_cnt + 16'h0001;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // interrupt flag and pin
    // =========================================================
    // set wins over a clear in the same cycle
    assign next_flag = trig | (flag & ~cmd1_done);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    assign int_n_out = 1'b0;
    assign int_n_oe  = flag;

    // =========================================================
    // led drive and modulation
    // =========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mod_cnt   <= 7'h0;
            mod_phase <= 1'b0;
        end else if (mod_cnt == MOD_LAST) begin
            mod_cnt   <= 7'h0;
            mod_phase <= ~mod_phase;
        end else begin
            mod_cnt <= mod_cnt + 7'h01;
        end
    end

    wire prox_on = (state == ST_INTEG) & mode[0];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_drive_output <= 1'b0;
        end else begin
            // dc when freq is low, square wave when high
            led_drive_output <= prox_on &
                                (~freq | mod_phase);
        end
    end

endmodule

/* File: test/ir_conv_model.sv */
`timescale 1ns/10ps
module ir_conv_model (
    // bench control
    input  wire logic pulse_en,
    // converter pins
    output logic      osc_clk,
    output logic      photo_pulse
);
    initial begin
        osc_clk = 1'b0;
        forever #80 osc_clk = ~osc_clk;
    end
    // one charge pulse per oscillator period while lit
    initial begin
        photo_pulse = 1'b0;
        forever begin
            @(posedge osc_clk);
            #40 photo_pulse = pulse_en;
            #20 photo_pulse = 1'b0;
        end
    end
endmodule

/* File: test/ir_prox_properties.sv */
`timescale 1ns/10ps
module ir_prox_checker (
    // clock and reset
    input wire        hclk,
    input wire        hresetn,
    // bus
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // converter, led, interrupt
    input wire        adc_active,
    input wire [1:0]  adc_range,
    input wire [15:0] result_mask,
    input wire        led_drive_output,
    input wire [1:0]  led_current,
    input wire        int_n_out,
    input wire        int_n_oe
);
    reg       ph_v;
    reg       ph_w;
    reg [2:0] ph_i;
    reg [2:0] mode_q;
    wire      acc0 = ph_v && ph_i == 3'h0;
    wire      wr0  = acc0 && ph_w;
    wire      wr1  = ph_v && ph_w && ph_i == 3'h1;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ====================================
    // data-phase tracker
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v <= 1'b0;
            ph_w <= 1'b0;
            ph_i <= 3'h0;
            mode_q <= 3'h0;
        end else begin
            ph_v <= hsel && htrans[1] && hready && haddr[31:5] == 27'h0;
            ph_w <= hwrite;
            ph_i <= haddr[4:2];
            mode_q <= wr0 ? hwdata[7:5] : mode_q;
        end
    end
    // ====================================
    // properties
    chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus response not okay");
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    chk_int_drain: assert property (int_n_out == 1'b0)
        else $error("interrupt pin drives high");
    chk_mode_start: assert property (wr0 |=> adc_active == $past(hwdata[6]))
        else $error("mode write not adopted");
    chk_range_follow: assert property (wr1 |=> adc_range == $past(hwdata[1:0]))
        else $error("range not applied");
    chk_led_amp: assert property (wr1 |=> led_current == $past(hwdata[5:4]))
        else $error("led amplitude not applied");
    chk_mask_legal: assert property (result_mask == 16'hffff
        || result_mask == 16'h0fff || result_mask == 16'h00ff
        || result_mask == 16'h000f) else $error("bad result width");
    chk_led_idle: assert property (!adc_active && !$fell(adc_active)
        |-> !led_drive_output) else $error("led on while idle");
    chk_ir_led_off: assert property (!mode_q[0] && !$past(mode_q[0])
        && !$past(mode_q[0], 2) |-> !led_drive_output)
        else $error("led on in ir mode");
    chk_flag_hold: assert property (int_n_oe && !acc0 |=> int_n_oe)
        else $error("interrupt dropped early");
    chk_flag_clear: assert property (acc0 && !adc_active |=> !int_n_oe)
        else $error("interrupt not cleared");
endmodule
bind ir_proximity_sensor_sequencer ir_prox_checker u_ir_prox_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .adc_active(adc_active), .adc_range(adc_range),
    .result_mask(result_mask), .led_drive_output(led_drive_output),
    .led_current(led_current), .int_n_out(int_n_out), .int_n_oe(int_n_oe)
);

/* File: test/ir_proximity_sensor_sequencer_test.sv */
`timescale 1ns/10ps
module ir_proximity_sensor_sequencer_test;
    logic        hclk, hresetn, hsel, hwrite, pulse_en;
    logic [31:0] haddr, hwdata, hrdata, rd, exp;
    logic [1:0]  htrans, adc_range, led_current;
    logic        hreadyout, hresp, osc_clk, photo_pulse, adc_active;
    logic        led_drive_output, int_n_out, int_n_oe;
    logic [15:0] result_mask;
    int          err_count, checks_done, i;

    ir_proximity_sensor_sequencer u_ir_proximity_sensor_sequencer (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .osc_clk(osc_clk), .photo_pulse(photo_pulse),
        .adc_active(adc_active), .adc_range(adc_range),
        .result_mask(result_mask), .led_drive_output(led_drive_output),
        .led_current(led_current), .int_n_out(int_n_out),
        .int_n_oe(int_n_oe));
    ir_conv_model u_ir_conv_model (.pulse_en(pulse_en),
        .osc_clk(osc_clk), .photo_pulse(photo_pulse));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // ====================================
    // bus and compare tasks
    task automatic check(input string nm, input logic [31:0] seen, ex);
        checks_done++;
        if (seen !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        // state flop moves on at the edge that ends the write
        @(posedge hclk);
        while (adc_active !== 1'b0 && n < 40000) begin
            @(posedge hclk);
            n++;
        end
        check("idle", adc_active, 0);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge hclk);
        err_count++;
        end_of_test();
    end
    // ====================================
    // tests
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pulse_en = 1'b1;
        err_count = 0;
        checks_done = 0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 8; i++) begin
            xfer(0, i * 4, 8'h00);
            check("reset value", rd, (i > 5) ? 32'hff : 32'h0);
        end
        xfer(0, 32'h20, 8'h00);
        check("unmapped", rd, 32'h0);
        check("powered down", adc_active, 0);
        for (i = 3; i > 0; i--) begin
            exp = (32'h1 << (16 - 4 * i)) - 1;
            xfer(1, 4, i * 4);
            xfer(1, 0, 8'h40);
            wait_idle();
            xfer(0, 8, 8'h00);
            check("data lsb", rd, exp[7:0]);
            xfer(0, 12, 8'h00);
            check("data msb", rd, exp[15:8]);
            check("mask", result_mask, exp);
            xfer(0, 0, 8'h00);
            check("self power-down", rd, 32'h0);
        end
        xfer(1, 4, 8'had);
        xfer(1, 0, 8'he0);
        repeat (4) @(posedge hclk);
        check("led prox", led_drive_output, 1);
        check("led amp", led_current, 2);
        check("range", adc_range, 1);
        xfer(1, 0, 8'hc0);
        repeat (4) @(posedge hclk);
        check("led ir", led_drive_output, 0);
        check("ir running", adc_active, 1);
        xfer(1, 0, 8'h00);
        @(posedge hclk);
        check("stopped", adc_active, 0);
        xfer(1, 24, 8'h0a);
        xfer(1, 28, 8'h00);
        xfer(1, 0, 8'h40);
        wait_idle();
        check("int above", int_n_oe, 1);
        xfer(0, 0, 8'h00);
        check("flag bit", rd, 32'h04);
        @(posedge hclk);
        check("int cleared", int_n_oe, 0);
        xfer(1, 24, 8'hff);
        xfer(1, 16, 8'h05);
        pulse_en <= 1'b0;
        xfer(1, 0, 8'hc1);
        repeat (444) @(posedge hclk);
        check("persist 3", int_n_oe, 0);
        repeat (128) @(posedge hclk);
        check("persist 4", int_n_oe, 1);
        xfer(0, 8, 8'h00);
        check("overwritten", rd, 32'h0);
        xfer(1, 0, 8'h00);
        @(posedge hclk);
        check("int off", int_n_oe, 0);
        check("off", adc_active, 0);
        xfer(1, 0, 8'h60);
        repeat (4) @(posedge hclk);
        check("led prox once", led_drive_output, 1);
        wait_idle();
        xfer(0, 0, 8'h00);
        check("prox once", rd, 32'h04);
        xfer(1, 0, 8'h20);
        xfer(0, 0, 8'h00);
        check("reserved mode", rd, 32'h20);
        check("reserved idle", adc_active, 0);
        xfer(1, 4, 8'hed);
        xfer(1, 0, 8'he0);
        repeat (4) @(posedge hclk);
        // two modulation periods of 138 cycles, half of them lit
        i = 0;
        repeat (276) begin
            @(posedge hclk);
            i += led_drive_output;
        end
        check("led modulated", i, 138);
        end_of_test();
    end
endmodule
